// ===== uls_pkg.sv
// package: register map, field positions and reset values of the line status flag block
package uls_pkg;

    localparam int ADDR_W = 8;

    localparam logic [ADDR_W-1:0] ADDR_LINE_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL     = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS  = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK    = 8'h0C;

    localparam int LS_DATA_ERR = 7;
    localparam int LS_TEMT     = 6;
    localparam int LS_THRE     = 5;
    localparam int LS_BREAK    = 4;
    localparam int LS_FRAME    = 3;

    localparam int CTL_FIFO_MODE = 0;
    localparam int CTL_THRE_IE   = 1;
    localparam int CTL_FRAME_LSB = 4;
    localparam int FRAME_W       = 4;

    localparam int IRQ_DATA_ERR = 0;
    localparam int IRQ_BREAK    = 1;
    localparam int IRQ_FRAME    = 2;
    localparam int IRQ_THRE     = 3;
    localparam int IRQ_W        = 4;

    localparam logic             LS_DATA_ERR_RST = 1'b0;
    localparam logic             LS_TEMT_RST     = 1'b1;
    localparam logic             LS_THRE_RST     = 1'b1;
    localparam logic             LS_BREAK_RST    = 1'b0;
    localparam logic             LS_FRAME_RST    = 1'b0;
    localparam logic             FIFO_MODE_RST   = 1'b0;
    localparam logic             THRE_IE_RST     = 1'b0;
    localparam logic [FRAME_W-1:0] FRAME_BITS_RST = 4'hA;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST    = 4'h0;
    localparam logic [IRQ_W-1:0] IRQ_STAT_RST    = 4'h0;

    typedef enum logic [1:0] {
        ULS_LINE_IDLE,
        ULS_LINE_LOW,
        ULS_LINE_BREAK
    } uls_line_e;

endpackage

// ===== uls_brk_if.sv
// interface: receive line and frame length toward the break detector, break pulse back
`timescale 1ns/1ps
interface uls_brk_if;
    logic                        rxd;
    logic                        bit_tick;
    logic [uls_pkg::FRAME_W-1:0] frame_bits;
    logic                        brk_pulse;

    modport core (
        output rxd,
        output bit_tick,
        output frame_bits,
        input  brk_pulse
    );

    modport det (
        input  rxd,
        input  bit_tick,
        input  frame_bits,
        output brk_pulse
    );
endinterface

// ===== uls_brk_det.sv
// break detector: counts bit times with the line low, one pulse per break
`timescale 1ns/1ps
module uls_brk_det (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    uls_brk_if.det   brk
);
    import uls_pkg::*;

    uls_line_e              state_r;
    logic [FRAME_W-1:0]     low_cnt_r;
    logic                   pulse_r;

    assign brk.brk_pulse = pulse_r;

    // line high ends the condition and rearms; only one pulse per low stretch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r   <= ULS_LINE_IDLE;
            low_cnt_r <= '0;
            pulse_r   <= 1'b0;
        end else if (ce) begin
            pulse_r <= 1'b0;
            case (state_r)
                ULS_LINE_IDLE: begin
                    low_cnt_r <= '0;
                    if (!brk.rxd) begin
                        state_r <= ULS_LINE_LOW;
                    end
                end
                ULS_LINE_LOW: begin
                    if (brk.rxd) begin
                        state_r <= ULS_LINE_IDLE;
                    end else if (brk.bit_tick) begin
                        if (low_cnt_r + 1'b1 >= brk.frame_bits) begin
                            pulse_r <= 1'b1;
                            state_r <= ULS_LINE_BREAK;
                        end else begin
                            low_cnt_r <= low_cnt_r + 1'b1;
                        end
                    end
                end
                ULS_LINE_BREAK: begin
                    if (brk.rxd) begin
                        state_r <= ULS_LINE_IDLE;
                    end
                end
                default: begin
                    state_r <= ULS_LINE_IDLE;
                end
            endcase
        end
    end

    single_break_a: assert property (@(posedge pclk) disable iff (!presetn)
        pulse_r && ce |=> !pulse_r && (state_r == ULS_LINE_BREAK))
        else $error("second break pulse without line returning high");

    break_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(pulse_r) |-> $past(!brk.rxd) && $past(brk.bit_tick))
        else $error("break pulse without low line at a bit tick");

endmodule

// ===== uls_line_status.sv
// line status flag logic with apb register slave and interrupt
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
module uls_line_status #(
    parameter int ERR_CNT_W = 5
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        ce,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [uls_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        rxd,
    input  wire logic                        bit_tick,
    input  wire logic                        rx_push,
    input  wire logic                        rx_push_err,
    input  wire logic                        rx_push_fe,
    input  wire logic                        rx_pop,
    input  wire logic                        rx_pop_err,
    input  wire logic                        rx_not_empty,
    input  wire logic                        rx_top_fe,
    input  wire logic                        hold_write,
    input  wire logic                        hold_to_shift,
    input  wire logic                        shift_busy,
    input  wire logic                        tx_fifo_empty,
    output logic                             brk_push,
    output logic                             fifo_mode,
    output logic                             irq
);
    import uls_pkg::*;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == ADDR_LINE_STATUS) || (a == ADDR_CONTROL) ||
                    (a == ADDR_IRQ_STATUS) || (a == ADDR_IRQ_MASK);
    endfunction

    logic                   ls_data_err_r;
    logic                   ls_temt_r;
    logic                   ls_thre_r;
    logic                   ls_break_r;
    logic                   ls_frame_r;
    logic                   fifo_mode_r;
    logic                   thre_ie_r;
    logic [FRAME_W-1:0]     frame_bits_r;
    logic [IRQ_W-1:0]       irq_stat_r;
    logic [IRQ_W-1:0]       irq_mask_r;
    logic [ERR_CNT_W-1:0]   err_cnt_r;
    logic [31:0]            prdata_r;
    logic                   ls_thre_nxt;
    logic                   err_inc;
    logic                   err_dec;
    logic                   acc;
    logic                   wr_en;
    logic                   ls_read;
    logic                   fe_event;
    logic                   brk_pulse;
    logic [7:0]             line_status;
    logic [IRQ_W-1:0]       irq_event;

    uls_brk_if brk_bus ();

    assign brk_bus.rxd        = rxd;
    assign brk_bus.bit_tick   = bit_tick;
    assign brk_bus.frame_bits = frame_bits_r;
    assign brk_pulse          = brk_bus.brk_pulse;

    uls_brk_det u_brk_det (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .brk     (brk_bus.det)
    );

    // apb: one wait-free access phase while ce is high; ce low stalls the bus
    assign acc     = psel && penable && ce;
    assign pready  = ce;
    assign pslverr = psel && penable && !is_mapped(paddr);
    assign wr_en   = acc && pwrite && is_mapped(paddr);
    assign ls_read = acc && !pwrite && (paddr == ADDR_LINE_STATUS);
    assign prdata  = prdata_r;

    assign brk_push  = brk_pulse;
    assign fifo_mode = fifo_mode_r;

    assign line_status = {ls_data_err_r, ls_temt_r, ls_thre_r, ls_break_r, ls_frame_r, 3'h0};

    // read data latched in the setup cycle so it is stable at the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (ce && psel && !penable && !pwrite) begin
            case (paddr)
                ADDR_LINE_STATUS: prdata_r <= {24'h00_0000, line_status};
                ADDR_CONTROL: begin
                    prdata_r                                 <= 32'h0000_0000;
                    prdata_r[CTL_FIFO_MODE]                  <= fifo_mode_r;
                    prdata_r[CTL_THRE_IE]                    <= thre_ie_r;
                    prdata_r[CTL_FRAME_LSB +: FRAME_W]       <= frame_bits_r;
                end
                ADDR_IRQ_STATUS:  prdata_r <= {{(32-IRQ_W){1'b0}}, irq_stat_r};
                ADDR_IRQ_MASK:    prdata_r <= {{(32-IRQ_W){1'b0}}, irq_mask_r};
                default:          prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_mode_r  <= FIFO_MODE_RST;
            thre_ie_r    <= THRE_IE_RST;
            frame_bits_r <= FRAME_BITS_RST;
        end else if (wr_en && paddr == ADDR_CONTROL) begin
            fifo_mode_r  <= pwdata[CTL_FIFO_MODE];
            thre_ie_r    <= pwdata[CTL_THRE_IE];
            frame_bits_r <= pwdata[CTL_FRAME_LSB +: FRAME_W];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_r <= IRQ_MASK_RST;
        end else if (wr_en && paddr == ADDR_IRQ_MASK) begin
            irq_mask_r <= pwdata[IRQ_W-1:0];
        end
    end

    // count of held receive characters that carry parity, framing or break errors
    assign err_inc = rx_push && rx_push_err;
    assign err_dec = rx_pop && rx_pop_err && (err_cnt_r != '0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_cnt_r <= '0;
        end else if (ce) begin
            if (err_inc && !err_dec) begin
                err_cnt_r <= err_cnt_r + 1'b1;
            end else if (err_dec && !err_inc) begin
                err_cnt_r <= err_cnt_r - 1'b1;
            end
        end
    end

    // set wins over the read clear, so an error held in the fifo stays visible
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ls_data_err_r <= LS_DATA_ERR_RST;
        end else if (ce) begin
            if (err_cnt_r != '0 || err_inc) begin
                ls_data_err_r <= 1'b1;
            end else if (ls_read) begin
                ls_data_err_r <= 1'b0;
            end
        end
    end

    // holding empty: transfer event outside fifo mode, fifo level inside it
    always_comb begin
        ls_thre_nxt = ls_thre_r;
        if (fifo_mode_r) begin
            ls_thre_nxt = tx_fifo_empty && !hold_write;
        end else if (hold_to_shift) begin
            ls_thre_nxt = 1'b1;
        end else if (hold_write) begin
            ls_thre_nxt = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ls_thre_r <= LS_THRE_RST;
        end else if (ce) begin
            ls_thre_r <= ls_thre_nxt;
        end
    end

    // transmit empty needs the shift register idle and no character being loaded
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ls_temt_r <= LS_TEMT_RST;
        end else if (ce) begin
            if (shift_busy || hold_write || hold_to_shift) begin
                ls_temt_r <= 1'b0;
            end else if (fifo_mode_r) begin
                ls_temt_r <= tx_fifo_empty;
            end else begin
                ls_temt_r <= ls_thre_nxt;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ls_break_r <= LS_BREAK_RST;
        end else if (ce) begin
            if (brk_pulse) begin
                ls_break_r <= 1'b1;
            end else if (ls_read) begin
                ls_break_r <= 1'b0;
            end
        end
    end

    // fifo mode follows the top character; otherwise the character just received
    assign fe_event = fifo_mode_r ? (rx_not_empty && rx_top_fe) : (rx_push && rx_push_fe);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ls_frame_r <= LS_FRAME_RST;
        end else if (ce) begin
            if (fe_event) begin
                ls_frame_r <= 1'b1;
            end else if (ls_read) begin
                ls_frame_r <= 1'b0;
            end
        end
    end

    // sticky interrupt status, write one to clear, new event wins over the clear
    assign irq_event[IRQ_DATA_ERR] = err_inc;
    assign irq_event[IRQ_BREAK]    = brk_pulse;
    assign irq_event[IRQ_FRAME]    = fe_event && !ls_frame_r;
    assign irq_event[IRQ_THRE]     = ls_thre_nxt && !ls_thre_r;

    generate
        for (genvar i = 0; i < IRQ_W; i++) begin : g_irq
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    irq_stat_r[i] <= IRQ_STAT_RST[i];
                end else if (ce) begin
                    if (irq_event[i]) begin
                        irq_stat_r[i] <= 1'b1;
                    end else if (wr_en && paddr == ADDR_IRQ_STATUS && pwdata[i]) begin
                        irq_stat_r[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // the holding-empty request is a level on its own, independent of the sticky bits
    assign irq = (ls_thre_r && thre_ie_r) || (|(irq_stat_r & irq_mask_r));

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    data_err_set_a: assert property ((err_cnt_r != '0) && ce |=> ls_data_err_r)
        else $error("data error flag clear while errors are held");

    data_err_clr_a: assert property (ls_read && err_cnt_r == '0 && !err_inc |=> !ls_data_err_r)
        else $error("data error flag not cleared by status read");

    temt_hold_a: assert property (!fifo_mode_r && !$past(fifo_mode_r) && ls_temt_r |-> ls_thre_r)
        else $error("transmit empty while holding register full");

    temt_busy_a: assert property (ce && (shift_busy || hold_write) |=> !ls_temt_r)
        else $error("transmit empty while a character is held");

    temt_fifo_a: assert property (ce && fifo_mode_r && tx_fifo_empty && !shift_busy
                                  && !hold_write && !hold_to_shift |=> ls_temt_r)
        else $error("transmit empty missing in fifo mode");

    thre_set_a: assert property (ce && !fifo_mode_r && hold_to_shift |=> ls_thre_r)
        else $error("holding empty not set on transfer");

    thre_clr_a: assert property (ce && hold_write && !(hold_to_shift && !fifo_mode_r) |=> !ls_thre_r)
        else $error("holding empty not cleared on write");

    irq_thre_a: assert property (ls_thre_r && thre_ie_r |-> irq)
        else $error("holding empty interrupt missing");

    thre_fifo_a: assert property (ce && fifo_mode_r && tx_fifo_empty && !hold_write |=> ls_thre_r)
        else $error("holding empty not following empty fifo");

    break_set_a: assert property (ce && brk_pulse |=> ls_break_r && irq_stat_r[IRQ_BREAK])
        else $error("break flag or status not set");

    frame_set_a: assert property (ce && fe_event |=> ls_frame_r)
        else $error("framing error flag not set");

    flags_clr_a: assert property (ls_read && !brk_pulse && !fe_event |=> !ls_break_r && !ls_frame_r)
        else $error("break or framing flag survived status read");

endmodule

// ===== uls_tx_model.sv
// transmit path model: holding register or fifo count plus a shift register with a fixed shift time
`timescale 1ns/1ps
module uls_tx_model #(
    parameter int SHIFT_CYC = 40
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic load,
    input  wire logic hold,
    output logic      hold_write,
    output logic      hold_to_shift,
    output logic      shift_busy,
    output logic      tx_fifo_empty
);
    int cnt_r;
    int shift_r;

    // hold keeps characters queued so the bench can look at a loaded holding stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r      <= 0;
            shift_r    <= 0;
            hold_write    <= 1'b0;
            hold_to_shift <= 1'b0;
        end else begin
            hold_write    <= load;
            hold_to_shift <= 1'b0;
            if (shift_r != 0) begin
                shift_r <= shift_r - 1;
            end
            if (load) begin
                cnt_r <= cnt_r + 1;
            end else if (cnt_r != 0 && shift_r == 0 && !hold && !hold_to_shift) begin
                cnt_r         <= cnt_r - 1;
                hold_to_shift <= 1'b1;
                shift_r       <= SHIFT_CYC;
            end
        end
    end

    assign shift_busy    = (shift_r != 0);
    assign tx_fifo_empty = (cnt_r == 0);
endmodule

// ===== test_uls_line_status.sv
// self-checking testbench of the line status flag block
`timescale 1ns/1ps
module test_uls_line_status;
    import uls_pkg::*;
    logic              pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata;
    logic              rxd, bit_tick, rx_push, rx_push_err, rx_push_fe, rx_pop, rx_pop_err;
    logic              rx_not_empty, rx_top_fe, hold_write, hold_to_shift, shift_busy, tx_fifo_empty;
    logic              brk_push, fifo_mode, irq, tx_load, tx_hold;
    int                n_fail, n_compared, n_brk, cyc;
    logic [31:0]       rd;
    logic              er;

    uls_line_status dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rxd(rxd), .bit_tick(bit_tick), .rx_push(rx_push), .rx_push_err(rx_push_err), .rx_push_fe(rx_push_fe),
        .rx_pop(rx_pop), .rx_pop_err(rx_pop_err), .rx_not_empty(rx_not_empty), .rx_top_fe(rx_top_fe),
        .hold_write(hold_write), .hold_to_shift(hold_to_shift), .shift_busy(shift_busy),
        .tx_fifo_empty(tx_fifo_empty),
        .brk_push(brk_push), .fifo_mode(fifo_mode), .irq(irq));

    uls_tx_model tx_u (.pclk(pclk), .presetn(presetn), .load(tx_load), .hold(tx_hold), .hold_write(hold_write),
        .hold_to_shift(hold_to_shift), .shift_busy(shift_busy), .tx_fifo_empty(tx_fifo_empty));

    initial pclk = 1'b0;
    always #4 pclk = ~pclk;

    // the ceiling is far above the few hundred cycles the scenarios need
    always @(posedge pclk) begin
        cyc++;
        if (brk_push === 1'b1) n_brk++;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // only the bench timeout ends a stalled access
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // irq is a function of registers, so look at it once the write edge has settled
    task automatic irq_chk(input logic exp);
        @(negedge pclk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask

    task automatic push(input logic err, input logic fe, input logic pop);
        @(posedge pclk);
        rx_push      <= !pop;
        rx_pop       <= pop;
        rx_push_err  <= err;
        rx_push_fe   <= fe;
        rx_pop_err   <= err;
        rx_not_empty <= !pop;
        @(posedge pclk);
        rx_push <= 1'b0;
        rx_pop  <= 1'b0;
    endtask

    task automatic load(input logic h);
        @(posedge pclk);
        tx_load <= 1'b1;
        tx_hold <= h;
        @(posedge pclk);
        tx_load <= 1'b0;
    endtask

    task automatic release_tx;
        @(posedge pclk);
        tx_hold <= 1'b0;
        step(3);
    endtask

    task automatic tx_idle;
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (!(tx_fifo_empty === 1'b1 && shift_busy === 1'b0) && n < 500);
        step(2);
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge pclk);
            bit_tick <= 1'b1;
            @(posedge pclk);
            bit_tick <= 1'b0;
        end
    endtask

    task automatic t_reset;
        rd_chk(ADDR_LINE_STATUS, 32'h00000060);
        rd_chk(ADDR_CONTROL, 32'h000000A0);
        rd_chk(ADDR_IRQ_MASK, 32'h00000000);
        chk({30'h0, brk_push, irq}, 32'h00000000);
        apb(1'b0, 8'h10, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
    endtask

    task automatic t_tx_plain;
        wr(ADDR_CONTROL, 32'h000000A2);
        irq_chk(1'b1);
        load(1'b1);
        rd_chk(ADDR_LINE_STATUS, 32'h00000000);
        irq_chk(1'b0);
        release_tx();
        rd_chk(ADDR_LINE_STATUS, 32'h00000020);
        tx_idle();
        rd_chk(ADDR_LINE_STATUS, 32'h00000060);
    endtask

    task automatic t_tx_fifo;
        wr(ADDR_CONTROL, 32'h000000A3);
        @(negedge pclk);
        chk({31'h0, fifo_mode}, 32'h00000001);
        load(1'b1);
        load(1'b1);
        rd_chk(ADDR_LINE_STATUS, 32'h00000000);
        release_tx();
        rd_chk(ADDR_LINE_STATUS, 32'h00000000);
        tx_idle();
        rd_chk(ADDR_LINE_STATUS, 32'h00000060);
    endtask

    task automatic t_rx;
        wr(ADDR_CONTROL, 32'h000000A0);
        push(1'b1, 1'b1, 1'b0);
        rd_chk(ADDR_LINE_STATUS, 32'h000000E8);
        rd_chk(ADDR_LINE_STATUS, 32'h000000E0);
        push(1'b1, 1'b0, 1'b1);
        apb(1'b0, ADDR_LINE_STATUS, 32'h0);
        chk(rd, 32'h000000E0);
        rd_chk(ADDR_LINE_STATUS, 32'h00000060);
        wr(ADDR_CONTROL, 32'h000000A1);
        @(posedge pclk);
        rx_not_empty <= 1'b1;
        rx_top_fe    <= 1'b1;
        rd_chk(ADDR_LINE_STATUS, 32'h00000068);
        @(posedge pclk);
        rx_not_empty <= 1'b0;
        rx_top_fe    <= 1'b0;
        apb(1'b0, ADDR_LINE_STATUS, 32'h0);
        chk(rd, 32'h00000068);
        rd_chk(ADDR_LINE_STATUS, 32'h00000060);
    endtask

    // ce low must freeze the flags and stall the bus
    task automatic t_freeze;
        @(posedge pclk);
        ce <= 1'b0;
        push(1'b1, 1'b1, 1'b0);
        chk({31'h0, pready}, 32'h00000000);
        @(posedge pclk);
        ce <= 1'b1;
        rd_chk(ADDR_LINE_STATUS, 32'h00000060);
    endtask

    task automatic t_break;
        wr(ADDR_CONTROL, 32'h000000A0);
        wr(ADDR_IRQ_STATUS, 32'h0000000F);
        n_brk = 0;
        @(posedge pclk);
        rxd <= 1'b0;
        tick(9);
        step(3);
        chk(n_brk, 0);
        rd_chk(ADDR_LINE_STATUS, 32'h00000060);
        tick(3);
        step(3);
        chk(n_brk, 1);
        rd_chk(ADDR_LINE_STATUS, 32'h00000070);
        rd_chk(ADDR_IRQ_STATUS, 32'h00000002);
        irq_chk(1'b0);
        wr(ADDR_IRQ_MASK, 32'h00000002);
        irq_chk(1'b1);
        wr(ADDR_IRQ_STATUS, 32'h00000002);
        irq_chk(1'b0);
        @(posedge pclk);
        rxd <= 1'b1;
        rd_chk(ADDR_LINE_STATUS, 32'h00000060);
        wr(ADDR_IRQ_MASK, 32'h00000000);
    endtask

    initial begin
        {presetn, psel, penable, pwrite, bit_tick, rx_push, rx_push_err, rx_push_fe} = 8'h00;
        {rx_pop, rx_pop_err, rx_not_empty, rx_top_fe, tx_load, tx_hold} = 6'h00;
        {ce, rxd} = 2'h3;
        paddr  = '0;
        pwdata = '0;
        n_fail = 0;
        n_compared = 0;
        n_brk = 0;
        cyc = 0;
        step(8);
        presetn <= 1'b1;
        t_reset();
        t_tx_plain();
        t_tx_fifo();
        t_rx();
        t_freeze();
        t_break();
        wrap_up();
    end
endmodule
